// ===== src/token_ring_map.svh
`ifndef TOKEN_RING_MAP_SVH
`define TOKEN_RING_MAP_SVH

// register offsets
`define RAMP_SELECT_OFS    8'hD0
`define CONDUCTION_MODE_OFS 8'hD2
`define MISC_LOOP_OFS      8'hEA
// field positions
`define RAMP_AMP_LSB       1
`define RAMP_AMP_MSB       3
`define MODE_FCCM_BIT      0
`define RAMP_RST_SEL_BIT   3
// reset values
`define RAMP_SELECT_RST    8'h00
`define CONDUCTION_MODE_RST 8'h00
`define MISC_LOOP_RST      16'h0008
// timing: least spacing between turn-on requests
`define SET_SPACING_NS     50
`define CLK_PERIOD_NS      50
`define SET_SPACING_CYC    ((`SET_SPACING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// token pulse width in cycles
`define TOKEN_PULSE_CYC    4
// ramp rise period in cycles
`define RAMP_RISE_CYC      4

`endif

// ===== src/token_ring_pkg.sv
package token_ring_pkg;
   typedef enum logic [1:0] {
      ROLE_UNKNOWN,
      ROLE_MASTER,
      ROLE_SLAVE
   } role_e;
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ARMED,
      PH_ON
   } phase_e;
   typedef logic [7:0] reg_addr_t;
endpackage

// ===== src/ramp_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "token_ring_map.svh"

module ramp_gen
   import token_ring_pkg::*;
#(
   parameter int RW = 12
)
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // control
   input  wire logic          enable,
   input  wire logic          reset_pulse,
   input  wire logic [2:0]    amp_sel,
   input  wire logic [RW-1:0] discharge_step,
   // ramp level
   output logic      [RW-1:0] ramp
);
   logic [3:0]    rise_cnt;
   wire  [RW-1:0] rise_step = RW'({amp_sel, 4'h0}) + RW'(16);
   wire  rising = rise_cnt != 4'h0;

   always_ff @(posedge clk)
   begin
      if (sys_rst || !enable)
      begin
         ramp     <= '0;
         rise_cnt <= 4'h0;
      end
      else if (reset_pulse)
      begin
         rise_cnt <= 4'(`RAMP_RISE_CYC);
      end
      else if (rising)
      begin
         ramp     <= ramp + rise_step;
         rise_cnt <= rise_cnt - 4'h1;
      end
      else
      begin
         ramp <= (ramp > discharge_step) ? ramp - discharge_step : '0;
      end
   end
endmodule
`default_nettype wire

// ===== src/token_ring_sequencer.sv
// Notes on behaviour
// - token input held high at power-up makes this phase master.
// - role resolved once after reset; others are slaves.
// - master answers register writes and reads.
// - slave accepts writes; reads answered only by master.
// - master makes turn-on requests and owns sequencing and faults.
// - slave drives faults onto alert line; master watches it.
// - master launches the first on-pulse after start-up.
// - only the armed phase acts on a broadcast request.
// - switching on emits a fixed-width token pulse.
// - falling token input arms the phase.
// - switch turns off when the on-time expires.
// - requests may come as little as 50ns apart.
// - master ramp rises per request, decays, fires on crossing.
// - three-bit field selects ramp amplitude.
// - ramp-reset select: 0 by modulator pulse, 1 by request.
// - mode bit 1 forced continuous, 0 pulse-skip.
`timescale 1ns/1ns
`default_nettype none
`include "token_ring_map.svh"

module token_ring_sequencer
   import token_ring_pkg::*;
#(
   parameter int RW     = 12,
   parameter int ON_W   = 10
)
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            sys_rst,
   // token ring
   input  wire logic            token_in,
   output logic                 token_out,
   // broadcast request line (driven by master)
   input  wire logic            set_in,
   output logic                 set_out,
   output logic                 set_oe_n,
   // shared fault alert line, open drain
   input  wire logic            fault_alert_line_in,
   output logic                 fault_alert_line_out,
   output logic                 fault_alert_line_oe_n,
   // local conditions
   input  wire logic            ov_fault,
   input  wire logic            uv_fault,
   input  wire logic            ot_fault,
   input  wire logic            power_ok,
   input  wire logic            modulator_pulse,
   input  wire logic            light_load,
   // loop sensing, digital levels
   input  wire logic [RW-1:0]   feedback_sense,
   input  wire logic [RW-1:0]   compare_level,
   input  wire logic [RW-1:0]   discharge_step,
   input  wire logic [ON_W-1:0] on_time_cycles,
   // register port
   input  wire logic [7:0]      reg_addr,
   input  wire logic [15:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [15:0]     reg_rdata,
   output logic                 reg_rvalid,
   // status
   output logic                 high_side_switch,
   output logic                 is_master,
   output logic                 slave_fault_seen,
   output logic                 forced_continuous_conduction
);
   // ************************************************
   // registers
   // ************************************************
   logic [7:0]  ramp_select_cmd;
   logic [7:0]  conduction_mode_cmd;
   logic [15:0] misc_loop_cmd;
   role_e       role;
   phase_e      state;
   logic        token_d;
   logic        rearm;
   logic        started;
   logic [ON_W-1:0] on_cnt;
   logic [2:0]  tok_cnt;
   logic [1:0]  gap_cnt;
   logic [RW-1:0] ramp;

   wire master = role == ROLE_MASTER;
   wire token_fall = token_d && !token_in;

   wire rd_ok = reg_rd && master;
   wire [15:0] rd_mux =
      (reg_addr == `RAMP_SELECT_OFS)     ? {8'h00, ramp_select_cmd} :
      (reg_addr == `CONDUCTION_MODE_OFS) ? {8'h00, conduction_mode_cmd} :
      (reg_addr == `MISC_LOOP_OFS)       ? misc_loop_cmd : 16'h0000;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ramp_select_cmd     <= `RAMP_SELECT_RST;
         conduction_mode_cmd <= `CONDUCTION_MODE_RST;
         misc_loop_cmd       <= `MISC_LOOP_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `RAMP_SELECT_OFS)
            ramp_select_cmd <= reg_wdata[7:0];
         if (reg_addr == `CONDUCTION_MODE_OFS)
            conduction_mode_cmd <= reg_wdata[7:0];
         if (reg_addr == `MISC_LOOP_OFS)
            misc_loop_cmd <= reg_wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= rd_ok;
         reg_rdata  <= rd_ok ? rd_mux : 16'h0000;
      end
   end

   // ************************************************
   // role detection
   // ************************************************
   // strap sampled after reset release
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         role <= ROLE_UNKNOWN;
      else if (role == ROLE_UNKNOWN)
         role <= token_in ? ROLE_MASTER : ROLE_SLAVE;
   end

   // ************************************************
   // ramp and request generation
   // ************************************************
   // reset source select
   wire ramp_rst_sel = misc_loop_cmd[`RAMP_RST_SEL_BIT];
   wire ramp_reset   = ramp_rst_sel ? set_out : modulator_pulse;
   wire [2:0] amp_sel = ramp_select_cmd[`RAMP_AMP_MSB:`RAMP_AMP_LSB];

   ramp_gen #(.RW(RW)) u_ramp (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .enable         (master),
      .reset_pulse    (ramp_reset),
      .amp_sel        (amp_sel),
      .discharge_step (discharge_step),
      .ramp           (ramp)
   );

   wire fccm = conduction_mode_cmd[`MODE_FCCM_BIT];
   wire skip = !fccm && light_load;
   // sum widened by one bit; wrap would fake an early crossing
   wire [RW:0] fb_ramp = {1'b0, feedback_sense} + {1'b0, ramp};
   // spacing one cycle at 20 MHz
   wire want_set = master && started && power_ok && !skip
                   && gap_cnt == 2'd0
                   && fb_ramp <= {1'b0, compare_level};
   wire first_set = master && !started && power_ok;
   wire next_set  = want_set || first_set;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         set_out  <= 1'b0;
         set_oe_n <= 1'b1;
         started  <= 1'b0;
         gap_cnt  <= 2'd0;
      end
      else
      begin
         set_out  <= next_set;
         set_oe_n <= !master;
         if (first_set)
            started <= 1'b1;
         if (next_set)
            gap_cnt <= 2'(`SET_SPACING_CYC - 1);
         else if (gap_cnt != 2'd0)
            gap_cnt <= gap_cnt - 2'd1;
      end
   end

   // ************************************************
   // phase sequencing
   // ************************************************
   wire set_seen = master ? set_out : set_in;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         token_d <= 1'b1;
      else
         token_d <= token_in;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || role == ROLE_UNKNOWN)
      begin
         state            <= PH_IDLE;
         on_cnt           <= '0;
         high_side_switch <= 1'b0;
         rearm            <= 1'b0;
      end
      else
      begin
         case (state)
            PH_IDLE:
            begin
               if (token_fall || (master && first_set))
                  state <= PH_ARMED;
            end
            PH_ARMED:
            begin
               if (set_seen)
               begin
                  state            <= PH_ON;
                  high_side_switch <= 1'b1;
                  on_cnt           <= on_time_cycles;
               end
            end
            PH_ON:
            begin
               // keep a fall seen while on
               rearm <= (rearm || token_fall) && on_cnt > ON_W'(1);
               if (on_cnt <= ON_W'(1))
               begin
                  high_side_switch <= 1'b0;
                  state <= (token_fall || rearm) ? PH_ARMED : PH_IDLE;
               end
               else
                  on_cnt <= on_cnt - ON_W'(1);
            end
            default:
               state <= PH_IDLE;
         endcase
      end
   end

   wire launch = state == PH_ARMED && set_seen;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         tok_cnt   <= 3'd0;
         token_out <= 1'b0;
      end
      else if (launch)
      begin
         tok_cnt   <= 3'(`TOKEN_PULSE_CYC - 1);
         token_out <= 1'b1;
      end
      else if (tok_cnt != 3'd0)
         tok_cnt <= tok_cnt - 3'd1;
      else
         token_out <= 1'b0;
   end

   // ************************************************
   // fault alert line
   // ************************************************
   // slave pulls low, master listens
   wire local_fault = ov_fault || uv_fault || ot_fault;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         fault_alert_line_out  <= 1'b1;
         fault_alert_line_oe_n <= 1'b1;
         slave_fault_seen      <= 1'b0;
         is_master             <= 1'b0;
         forced_continuous_conduction <= 1'b0;
      end
      else
      begin
         fault_alert_line_out  <= 1'b0;
         fault_alert_line_oe_n <= !(role == ROLE_SLAVE && local_fault);
         slave_fault_seen      <= master && !fault_alert_line_in;
         is_master             <= master;
         forced_continuous_conduction <= fccm;
      end
   end

   // ************************************************
   // checks
   // ************************************************
   a_unarmed_ignores: assert property (@(posedge clk) disable iff (sys_rst)
      (state == PH_IDLE && !(master && first_set)) |=> !$rose(high_side_switch))
      else $error("switch on without arm");
   a_token_with_on: assert property (@(posedge clk) disable iff (sys_rst)
      launch |=> token_out && high_side_switch)
      else $error("token pulse not with switch on");
   a_arm_on_fall: assert property (@(posedge clk) disable iff (sys_rst)
      (token_fall && state == PH_IDLE && role != ROLE_UNKNOWN)
      |=> state == PH_ARMED)
      else $error("falling token did not arm");
   a_arm_cleared: assert property (@(posedge clk) disable iff (sys_rst)
      launch |=> state == PH_ON)
      else $error("arm not cleared");
   a_slave_no_read: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && role == ROLE_SLAVE) |=> !reg_rvalid)
      else $error("slave answered read");
   a_master_reads: assert property (@(posedge clk) disable iff (sys_rst)
      rd_ok |=> reg_rvalid && reg_rdata == $past(rd_mux))
      else $error("master read lost");
   a_role_stable: assert property (@(posedge clk) disable iff (sys_rst)
      role != ROLE_UNKNOWN |=> role == $past(role))
      else $error("role changed");
   a_slave_alert: assert property (@(posedge clk) disable iff (sys_rst)
      (role == ROLE_SLAVE && local_fault) |=> !fault_alert_line_oe_n)
      else $error("slave fault not signalled");
   a_no_set_slave: assert property (@(posedge clk) disable iff (sys_rst)
      role == ROLE_SLAVE |=> set_oe_n && !set_out)
      else $error("slave drove request");
endmodule
`default_nettype wire

// ===== bench/ring_partner.sv
`timescale 1ns/1ns
`default_nettype none

// ****
// rest of the ring: returns the token after a delay
// ****
module ring_partner
#(
   parameter int DLY = 20
)
(
   // clock
   input  wire logic clk,
   // ring
   input  wire logic token_from_dut,
   output var  logic token_to_dut
);
   // idle high so the phase resolves as master
   initial token_to_dut = 1'b1;
   // loop closed back to the token input
   always
   begin
      @(negedge token_from_dut);
      repeat (DLY) @(negedge clk);
      token_to_dut = 1'b0;
      repeat (4) @(negedge clk);
      token_to_dut = 1'b1;
   end
endmodule
`default_nettype wire

// ===== bench/token_ring_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none

module token_ring_sequencer_tb
   import token_ring_pkg::*;
;
   logic        clk = 1'b0;
   logic        sys_rst, tb_token, use_tb, tb_set, power_ok, ext_fault;
   logic        ov_fault, wr, rd, light_load;
   logic [11:0] fb, cmp;
   logic [9:0]  on_t;
   logic [7:0]  addr;
   logic [15:0] wdata;
   wire  logic [15:0] rdata;
   wire  logic  rvalid, token_out, set_out, set_oe_n, fal_out, fal_oe_n;
   wire  logic  hss, is_master, sfs, fcc, ring_ret;
   // tb picks the token source; set line and alert line resolved here
   wire  logic  token_in = use_tb ? tb_token : ring_ret;
   wire  logic  set_in   = set_oe_n ? tb_set : set_out;
   wire  logic  fal_line = (fal_oe_n & ~ext_fault) ? 1'b1 : fal_out;
   int          fails = 0;
   int          checks = 0;
   int          t;

   always #25 clk = ~clk;

   token_ring_sequencer dut_u (.clk(clk), .sys_rst(sys_rst),
      .token_in(token_in), .token_out(token_out), .set_in(set_in),
      .set_out(set_out), .set_oe_n(set_oe_n),
      .fault_alert_line_in(fal_line), .fault_alert_line_out(fal_out),
      .fault_alert_line_oe_n(fal_oe_n), .ov_fault(ov_fault),
      .uv_fault(1'b0), .ot_fault(1'b0), .power_ok(power_ok),
      .modulator_pulse(1'b0), .light_load(light_load), .feedback_sense(fb),
      .compare_level(cmp), .discharge_step(12'h010),
      .on_time_cycles(on_t), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
      .high_side_switch(hss), .is_master(is_master),
      .slave_fault_seen(sfs), .forced_continuous_conduction(fcc));

   ring_partner #(.DLY(20)) ring_u (.clk(clk), .token_from_dut(token_out),
      .token_to_dut(ring_ret));

   // ****
   // helpers
   // ****
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      // registered status follows one edge after the write lands
      @(negedge clk);
   endtask

   // answer stands from the taking edge until the next rising edge
   task automatic reg_read(input logic [7:0] a, input logic [15:0] exp,
                           input logic ok);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      check(rvalid, ok);
      if (ok)
         check(rdata, exp);
   endtask

   task automatic do_reset(input logic slave);
      use_tb = slave;
      tb_token = 1'b0;
      sys_rst = 1'b1;
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic wait_hss(input int n);
      t = 0;
      while (hss !== 1'b1 && t < n)
      begin
         @(negedge clk);
         t++;
      end
   endtask

   task automatic set_pulse();
      @(negedge clk);
      tb_set = 1'b1;
      @(negedge clk);
      tb_set = 1'b0;
   endtask

   // ****
   // scenarios
   // ****
   task automatic master_regs();
      do_reset(1'b0);
      check(is_master, 1'b1);
      reg_read(8'hD0, 16'h0000, 1'b1);
      reg_read(8'hD2, 16'h0000, 1'b1);
      reg_read(8'hEA, 16'h0008, 1'b1);
      reg_read(8'h10, 16'h0000, 1'b1);
      reg_write(8'hD2, 16'h0001);
      check(fcc, 1'b1);
      reg_write(8'hD2, 16'h0000);
      check(fcc, 1'b0);
      reg_write(8'hD0, 16'h000E);
      reg_read(8'hD0, 16'h000E, 1'b1);
      reg_write(8'hEA, 16'h0000);
      reg_read(8'hEA, 16'h0000, 1'b1);
      reg_write(8'hEA, 16'h0008);
      ext_fault = 1'b1;
      repeat (3) @(negedge clk);
      check(sfs, 1'b1);
      ext_fault = 1'b0;
   endtask

   task automatic master_ring();
      logic seen;
      int   n;
      seen = 1'b0;
      n = 0;
      fb = 12'h000;
      cmp = 12'h800;
      on_t = 10'd3;
      power_ok = 1'b1;
      wait_hss(60);
      check(hss, 1'b1);
      check(token_out, 1'b1);
      while (hss === 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      check(n[15:0], 16'd3);
      check(token_out, 1'b1);
      @(negedge clk);
      check(token_out, 1'b0);
      repeat (15)
      begin
         @(negedge clk);
         seen = seen | hss;
      end
      check(seen, 1'b0);
      wait_hss(40);
      check(hss, 1'b1);
      check(set_oe_n, 1'b0);
      check(set_out, 1'b1);
      @(negedge clk);
      check(set_out, 1'b1);
      light_load = 1'b1;
      @(negedge clk);
      check(set_out, 1'b0);
      light_load = 1'b0;
      fb = 12'h900;
      @(negedge clk);
      check(set_out, 1'b0);
      fb = 12'h000;
      @(negedge clk);
      check(set_out, 1'b1);
      power_ok = 1'b0;
   endtask

   task automatic slave_ring();
      do_reset(1'b1);
      check(is_master, 1'b0);
      check(set_oe_n, 1'b1);
      reg_read(8'hD2, 16'h0000, 1'b0);
      reg_write(8'hD2, 16'h0001);
      check(fcc, 1'b1);
      set_pulse();
      repeat (2) @(negedge clk);
      check(hss, 1'b0);
      tb_token = 1'b1;
      @(negedge clk);
      tb_token = 1'b0;
      repeat (2) @(negedge clk);
      set_pulse();
      wait_hss(3);
      check(hss, 1'b1);
      check(token_out, 1'b1);
      repeat (10) @(negedge clk);
      set_pulse();
      repeat (2) @(negedge clk);
      check(hss, 1'b0);
      ov_fault = 1'b1;
      repeat (3) @(negedge clk);
      check(fal_oe_n, 1'b0);
      check(fal_out, 1'b0);
      ov_fault = 1'b0;
   endtask

   // ****
   // main sequence and watchdog
   // ****
   initial
   begin
      {tb_set, power_ok, ext_fault, ov_fault, wr, rd, light_load} = '0;
      fb = 12'hFFF;
      cmp = 12'h000;
      on_t = 10'd3;
      addr = 8'h00;
      wdata = 16'h0000;
      master_regs();
      master_ring();
      slave_ring();
      report_and_stop();
   end

   // run needs well under 2000 cycles
   initial
   begin
      #200000;
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
